// >>> shared/vmsc_consts.vh
// Constants of the voltage monitor setting controller
`ifndef VMSC_CONSTS_VH
`define VMSC_CONSTS_VH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define VMSC_OFS_CTRL      8'h00
`define VMSC_OFS_STATUS    8'h04
`define VMSC_OFS_IRQ_STAT  8'h08
`define VMSC_OFS_IRQ_MASK  8'h0C
// ****************************************************************
// Field positions
// ****************************************************************
`define VMSC_CTRL_INHIBIT  0
`define VMSC_ST_STATE_LSB  0
`define VMSC_ST_MON_EN     4
`define VMSC_ST_PENDING    5
`define VMSC_ST_BUTTON     6
`define VMSC_ST_UNDERV     7
`define VMSC_IRQ_SETUP     0
`define VMSC_IRQ_STORED    1
`define VMSC_IRQ_LOCKED    2
`define VMSC_IRQ_PFAIL     3
`define VMSC_IRQ_W         4
// ****************************************************************
// Reset values
// ****************************************************************
`define VMSC_RST_CTRL      32'h0000_0000
`define VMSC_RST_MASK      4'h0
`define VMSC_FACTORY_MON   1'b1
// ****************************************************************
// Times, in their own units, and the clock rate
// ****************************************************************
`define VMSC_CLK_HZ        10000000
`define VMSC_NOMON_MS      2000
`define VMSC_LONG_MS       5000
`define VMSC_WINDOW_MS     30000
`define VMSC_SELFTEST_MS   1000
`define VMSC_DEBOUNCE_MS   20
`define VMSC_BLINK_MS      250
// Cycles from milliseconds (all are exact at this clock rate)
`define VMSC_MS2CYC(ms)    ((ms) * (`VMSC_CLK_HZ / 1000))
`endif

// >>> hw/vmsc_ctrl.v
// Voltage monitor setting controller with its AHB-Lite register slave
//
// Chosen here: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "vmsc_consts.vh"
module vmsc_ctrl #(
	parameter integer NOMON_CYC = `VMSC_MS2CYC(`VMSC_NOMON_MS),
	parameter integer LONG_CYC  = `VMSC_MS2CYC(`VMSC_LONG_MS),
	parameter integer WIN_CYC   = `VMSC_MS2CYC(`VMSC_WINDOW_MS),
	parameter integer TEST_CYC  = `VMSC_MS2CYC(`VMSC_SELFTEST_MS),
	parameter integer DEB_CYC   = `VMSC_MS2CYC(`VMSC_DEBOUNCE_MS),
	parameter integer BLINK_CYC = `VMSC_MS2CYC(`VMSC_BLINK_MS)
) (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	output wire        irq,
	input  wire        set_button,
	input  wire        bus_undervoltage,
	input  wire        nvm_blank,
	input  wire        nvm_mon_en,
	output reg         nvm_wr,
	output reg         nvm_wr_data,
	output reg         bus_run_en,
	output reg         bus_power_fail_led,
	output reg         system_fault_led,
	output reg         supply_on_led,
	output reg         config_error_led,
	output reg         auto_addr_prog_led,
	output reg         config_mode_led,
	output reg         led_zero,
	output reg         led_one
);

	// ************************************************************
	// States and helpers
	// ************************************************************
	localparam [2:0] S_TEST  = 3'd0;
	localparam [2:0] S_NOMON = 3'd1;
	localparam [2:0] S_RUN   = 3'd2;
	localparam [2:0] S_SETUP = 3'd3;
	localparam [2:0] S_LOCK  = 3'd4;

	// Saturating increment of a 32-bit timer
	function [31:0] sat_inc;
		input [31:0] v;
		begin
			sat_inc = (v == 32'hFFFF_FFFF) ? v : v + 32'h0000_0001;
		end
	endfunction

	// True when a timer has reached a cycle count
	function reached;
		input [31:0] v;
		input integer lim;
		begin
			reached = (v >= lim[31:0]);
		end
	endfunction

	reg  [2:0]  state_q;
	reg  [31:0] up_q;
	reg  [31:0] st_q;
	reg  [31:0] deb_q;
	reg         btn_q;
	reg  [31:0] hold_q;
	reg         long_done_q;
	reg         wait_rel_q;
	reg         mon_q;
	reg         pend_q;
	reg  [31:0] blink_cnt_q;
	reg         blink_q;
	reg  [2:0]  chase_q;
	reg         inhibit_q;
	reg  [3:0]  istat_q;
	reg  [3:0]  imask_q;
	reg         wr_pend_q;
	reg  [7:0]  wr_addr_q;

	wire long_ev  = btn_q && !long_done_q && reached(hold_q, LONG_CYC);
	wire brief_ev = !btn_q && hold_q != 32'h0 && !long_done_q
		&& !wait_rel_q;
	wire in_win   = !reached(up_q, WIN_CYC);
	wire pfail    = mon_q && bus_undervoltage && state_q == S_RUN;

	// ************************************************************
	// Debounce and press timing
	// ************************************************************
	// Debounced level follows the pin after it is stable DEB_CYC
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			deb_q <= 32'h0;
			btn_q <= 1'b0;
		end else if (set_button == btn_q) begin
			deb_q <= 32'h0;
		end else if (reached(deb_q, DEB_CYC - 1)) begin
			deb_q <= 32'h0;
			btn_q <= set_button;
		end else begin
			deb_q <= sat_inc(deb_q);
		end
	end

	// Hold timer; long_done marks a press already used as long
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hold_q      <= 32'h0;
			long_done_q <= 1'b0;
		end else if (btn_q) begin
			hold_q <= sat_inc(hold_q);
			if (long_ev)
				long_done_q <= 1'b1;
		end else begin
			hold_q      <= 32'h0;
			long_done_q <= 1'b0;
		end
	end

	// Uptime for the entry window and blink divider
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			up_q        <= 32'h0;
			blink_cnt_q <= 32'h0;
			blink_q     <= 1'b0;
			chase_q     <= 3'd0;
		end else begin
			up_q <= sat_inc(up_q);
			if (reached(blink_cnt_q, BLINK_CYC - 1)) begin
				blink_cnt_q <= 32'h0;
				blink_q     <= ~blink_q;
				chase_q     <= (chase_q == 3'd5) ? 3'd0
					: chase_q + 3'd1;
			end else begin
				blink_cnt_q <= sat_inc(blink_cnt_q);
			end
		end
	end

	// ************************************************************
	// Operating sequence
	// ************************************************************
	// Main sequencer; stored setting loaded from storage at boot
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q     <= S_TEST;
			st_q        <= 32'h0;
			mon_q       <= `VMSC_FACTORY_MON;
			pend_q      <= `VMSC_FACTORY_MON;
			wait_rel_q  <= 1'b0;
			nvm_wr      <= 1'b0;
			nvm_wr_data <= `VMSC_FACTORY_MON;
		end else begin
			nvm_wr <= 1'b0;
			st_q   <= sat_inc(st_q);
			if (!btn_q)
				wait_rel_q <= 1'b0;
			case (state_q)
			S_TEST: begin
				// Blank storage reads as enabled
				mon_q <= nvm_blank ? `VMSC_FACTORY_MON
					: nvm_mon_en;
				if (btn_q) begin
					state_q <= S_LOCK;
				end else if (reached(st_q, TEST_CYC)) begin
					st_q    <= 32'h0;
					state_q <= mon_q ? S_RUN : S_NOMON;
				end
			end
			S_NOMON: begin
				if (reached(st_q, NOMON_CYC))
					state_q <= S_RUN;
			end
			S_RUN: begin
				if (long_ev && in_win) begin
					state_q    <= S_SETUP;
					pend_q     <= mon_q;
					wait_rel_q <= 1'b1;
				end
			end
			S_SETUP: begin
				if (brief_ev) begin
					pend_q <= ~pend_q;
				end else if (long_ev) begin
					mon_q       <= pend_q;
					nvm_wr      <= 1'b1;
					nvm_wr_data <= pend_q;
					state_q     <= S_RUN;
				end
			end
			S_LOCK: state_q <= S_LOCK;
			default: state_q <= S_LOCK;
			endcase
		end
	end

	// ************************************************************
	// LED and bus outputs, registered
	// ************************************************************
	// Front panel pattern per state
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_power_fail_led <= 1'b0;
			system_fault_led   <= 1'b0;
			supply_on_led      <= 1'b0;
			config_error_led   <= 1'b0;
			auto_addr_prog_led <= 1'b0;
			config_mode_led    <= 1'b0;
			led_zero           <= 1'b0;
			led_one            <= 1'b0;
			bus_run_en         <= 1'b0;
		end else begin
			bus_power_fail_led <= 1'b0;
			system_fault_led   <= 1'b0;
			supply_on_led      <= 1'b0;
			config_error_led   <= 1'b0;
			auto_addr_prog_led <= 1'b0;
			config_mode_led    <= 1'b0;
			led_zero           <= 1'b0;
			led_one            <= 1'b0;
			bus_run_en         <= 1'b0;
			case (state_q)
			S_TEST: begin
				// All lit until the test ends
				bus_power_fail_led <= 1'b1;
				system_fault_led   <= 1'b1;
				supply_on_led      <= 1'b1;
				config_error_led   <= 1'b1;
				auto_addr_prog_led <= 1'b1;
				config_mode_led    <= 1'b1;
				led_zero           <= 1'b1;
				led_one            <= 1'b1;
			end
			S_NOMON: begin
				bus_power_fail_led <= blink_q;
				led_zero           <= blink_q;
				supply_on_led      <= 1'b1;
			end
			S_RUN: begin
				supply_on_led      <= 1'b1;
				bus_power_fail_led <= pfail;
				bus_run_en <= !pfail && !inhibit_q;
			end
			S_SETUP: begin
				supply_on_led      <= 1'b1;
				bus_power_fail_led <= blink_q;
				led_one            <= pend_q;
				led_zero           <= !pend_q;
			end
			S_LOCK: begin
				// One LED at a time around the ring
				system_fault_led   <= chase_q == 3'd0;
				supply_on_led      <= chase_q == 3'd1;
				bus_power_fail_led <= chase_q == 3'd2;
				config_error_led   <= chase_q == 3'd3;
				auto_addr_prog_led <= chase_q == 3'd4;
				config_mode_led    <= chase_q == 3'd5;
			end
			default: bus_run_en <= 1'b0;
			endcase
		end
	end

	// ************************************************************
	// AHB-Lite register slave
	// ************************************************************
	wire       a_ok  = hsel && htrans[1] && hready;
	wire [3:0] ev    = {pfail, state_q == S_LOCK,
		state_q == S_SETUP && long_ev,
		state_q == S_RUN && long_ev && in_win};
	wire [3:0] clr   = (wr_pend_q && wr_addr_q == `VMSC_OFS_IRQ_STAT)
		? hwdata[3:0] : 4'h0;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign irq       = |(istat_q & imask_q);

	// Address phase capture and write data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			inhibit_q <= 1'b0;
			imask_q   <= `VMSC_RST_MASK;
			istat_q   <= 4'h0;
			hrdata    <= 32'h0000_0000;
		end else begin
			wr_pend_q <= a_ok && hwrite;
			wr_addr_q <= haddr;
			// Event set wins over a write-one clear
			istat_q   <= (istat_q & ~clr) | ev;
			if (wr_pend_q && wr_addr_q == `VMSC_OFS_CTRL)
				inhibit_q <= hwdata[`VMSC_CTRL_INHIBIT];
			if (wr_pend_q && wr_addr_q == `VMSC_OFS_IRQ_MASK)
				imask_q <= hwdata[3:0];
			hrdata <= 32'h0000_0000;
			if (a_ok && !hwrite) begin
				case (haddr)
				`VMSC_OFS_CTRL:
					hrdata <= {31'h0, inhibit_q};
				`VMSC_OFS_STATUS:
					hrdata <= {24'h0, bus_undervoltage, btn_q,
						pend_q, mon_q, 1'b0, state_q};
				`VMSC_OFS_IRQ_STAT:
					hrdata <= {28'h0, istat_q};
				`VMSC_OFS_IRQ_MASK:
					hrdata <= {28'h0, imask_q};
				default:
					hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule // vmsc_ctrl
`default_nettype wire

// >>> testbench/vmsc_props.sv
// Port checker of the voltage monitor setting controller
`timescale 1ns/100ps
`default_nettype none
// ****
// Checker
// ****
module vmsc_props (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        irq,
	input wire logic        set_button,
	input wire logic        bus_undervoltage,
	input wire logic        nvm_wr,
	input wire logic        bus_run_en,
	input wire logic        bus_power_fail_led,
	input wire logic        system_fault_led,
	input wire logic        supply_on_led,
	input wire logic        config_error_led,
	input wire logic        auto_addr_prog_led,
	input wire logic        config_mode_led,
	input wire logic        led_zero,
	input wire logic        led_one
);
	logic rd_q;
	wire  lit;
	// Every panel LED lit at once
	assign lit = &{system_fault_led, supply_on_led, config_error_led,
		auto_addr_prog_led, config_mode_led, bus_power_fail_led,
		led_zero, led_one};
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Marks the data phase of a taken read
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn) rd_q <= 1'h0;
		else rd_q <= hsel & htrans[1] & hready & !hwrite;
	property p_okay; hreadyout && !hresp; endproperty
	a_okay: assert property (p_okay) else $error("bus answer not OKAY");
	property p_rdata; !rd_q |-> hrdata == 32'h0000_0000; endproperty
	a_rdata: assert property (p_rdata) else $error("stray read data");
	property p_lit; $rose(hresetn) |-> ##3 lit; endproperty
	a_lit: assert property (p_lit) else $error("self-test dark");
	property p_idle; $rose(hresetn) |-> !bus_run_en [*8]; endproperty
	a_idle: assert property (p_idle) else $error("bus runs early");
	property p_pulse; nvm_wr |=> !nvm_wr; endproperty
	a_pulse: assert property (p_pulse) else $error("long store");
	property p_held;
		nvm_wr |-> $past(set_button, 40) && $past(set_button, 80);
	endproperty
	a_held: assert property (p_held) else $error("store w/o hold");
	property p_dark;
		nvm_wr && !bus_undervoltage |-> ##[1:3] !bus_power_fail_led;
	endproperty
	a_dark: assert property (p_dark) else $error("fail LED on");
	property p_uv;
		bus_undervoltage && bus_power_fail_led && !led_zero && !led_one
		|-> ##[1:3] !bus_run_en;
	endproperty
	a_uv: assert property (p_uv) else $error("bus runs in fail");
	c_store: cover property (nvm_wr);
	c_irq: cover property ($rose(irq));
	c_set: cover property (bus_power_fail_led && led_one);
endmodule // vmsc_props
bind vmsc_ctrl vmsc_props u_props (.hclk, .hresetn, .hsel, .htrans,
	.hwrite, .hready, .hreadyout, .hresp, .hrdata, .irq, .set_button,
	.bus_undervoltage, .nvm_wr, .bus_run_en, .bus_power_fail_led,
	.system_fault_led, .supply_on_led, .config_error_led,
	.auto_addr_prog_led, .config_mode_led, .led_zero, .led_one);
`default_nettype wire

// >>> testbench/vmsc_panel_model.sv
// Operator hand and setting storage beside the controller
`timescale 1ns/100ps
`default_nettype none
module vmsc_panel_model (
	input  wire logic hclk,
	input  wire logic press,
	input  wire logic nvm_wr,
	input  wire logic nvm_wr_data,
	output var  logic set_button,
	output var  logic nvm_blank,
	output var  logic nvm_mon_en
);
	// Storage keeps its content across resets; delivered blank
	// Button follows the hand; a store pulse writes the cell
	initial begin
		set_button = 1'h0;
		nvm_blank = 1'h1;
		nvm_mon_en = 1'h1;
		forever begin
			@(posedge hclk);
			set_button <= press;
			if (nvm_wr) begin
				nvm_blank <= 1'h0;
				nvm_mon_en <= nvm_wr_data;
			end
		end
	end
endmodule // vmsc_panel_model
`default_nettype wire

// >>> testbench/voltage_monitor_setting_ctrl_tb.sv
// Self-checking bench of the voltage monitor setting controller
`timescale 1ns/100ps
`default_nettype none
`include "vmsc_consts.vh"
module voltage_monitor_setting_ctrl_tb;
	localparam integer T = 20, N = 40, L = 100, W = 2000, D = 4, B = 8;
	logic        hclk, hresetn, hsel, hwrite, press, uv, on, off;
	logic [7:0]  haddr, acc;
	logic [1:0]  htrans;
	logic [31:0] hwdata, rd;
	wire         hrdy, hresp, irq, btn, blank, mon, nwr, nwd, run;
	wire  [31:0] hrdata;
	wire  [7:0]  led;
	integer      num_errors = 0, checks_done = 0, i;
	vmsc_ctrl #(.NOMON_CYC(N), .LONG_CYC(L), .WIN_CYC(W), .TEST_CYC(T),
		.DEB_CYC(D), .BLINK_CYC(B)) dut (.hclk, .hresetn, .hsel, .haddr,
		.htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hrdy),
		.hreadyout(hrdy), .hresp, .hrdata, .irq, .set_button(btn),
		.bus_undervoltage(uv), .nvm_blank(blank), .nvm_mon_en(mon),
		.nvm_wr(nwr), .nvm_wr_data(nwd), .bus_run_en(run),
		.bus_power_fail_led(led[7]), .system_fault_led(led[6]),
		.supply_on_led(led[5]), .config_error_led(led[4]),
		.auto_addr_prog_led(led[3]), .config_mode_led(led[2]),
		.led_zero(led[1]), .led_one(led[0]));
	vmsc_panel_model mdl (.hclk, .press, .nvm_wr(nwr), .nvm_wr_data(nwd),
		.set_button(btn), .nvm_blank(blank), .nvm_mon_en(mon));
	initial hclk = 1'h0;
	always #50 hclk = ~hclk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input integer n);
		repeat (n) @(posedge hclk);
	endtask
	// One single AHB transfer; read data is taken at its last edge
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge hclk); while (hrdy !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hrdy !== 1'h1);
		rd = hrdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, e);
		xfer(1'h0, a, 32'h0000_0000);
		check(rd & m, e);
	endtask
	task automatic st(input logic [31:0] e);
		rchk(`VMSC_OFS_STATUS, 32'h0000_0007, e);
	endtask
	task automatic hold(input integer n);
		press <= 1'h1;
		cyc(n);
		press <= 1'h0;
	endtask
	task automatic boot(input logic b);
		hresetn <= 1'h0;
		press <= b;
		cyc(4);
		hresetn <= 1'h1;
	endtask
	task automatic done(input string s);
		$display("test %0s finished", s);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Cuts a hung run short
	initial begin
		cyc(12000);
		num_errors++;
		end_of_test();
	end
	// Test sequence
	initial begin
		hresetn = 1'h0;
		hsel = 1'h0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'h0;
		hwdata = 32'h0000_0000;
		press = 1'h0;
		uv = 1'h0;
		boot(1'h0);
		cyc(3);
		check(led, 8'hff);
		cyc(T + 4);
		rchk(`VMSC_OFS_STATUS, 32'h0000_0017, 32'h0000_0012);
		check(run, 1'h1);
		check(led, 8'h20);
		done("boot");
		rchk(`VMSC_OFS_CTRL, 32'hffff_ffff, 32'h0000_0000);
		rchk(`VMSC_OFS_IRQ_MASK, 32'hffff_ffff, 32'h0000_0000);
		rchk(8'h10, 32'hffff_ffff, 32'h0000_0000);
		xfer(1'h1, `VMSC_OFS_CTRL, 32'h0000_0001);
		cyc(2);
		check(run, 1'h0);
		xfer(1'h1, `VMSC_OFS_CTRL, 32'h0000_0000);
		cyc(2);
		check(run, 1'h1);
		done("regs");
		// Undervoltage, masked then unmasked, then cleared
		uv <= 1'h1;
		cyc(4);
		check({led[7], run, irq}, 3'h4);
		rchk(`VMSC_OFS_STATUS, 32'h0000_00d7, 32'h0000_0092);
		xfer(1'h1, `VMSC_OFS_IRQ_MASK, 32'h0000_0008);
		cyc(1);
		check(irq, 1'h1);
		uv <= 1'h0;
		cyc(4);
		xfer(1'h1, `VMSC_OFS_IRQ_STAT, 32'h0000_000f);
		cyc(1);
		check({led[7], run, irq}, 3'h2);
		done("undervoltage");
		// Enter setting mode, toggle three times, store
		hold(D + L + 10);
		cyc(D + 4);
		st(32'h0000_0003);
		on = 1'h0;
		off = 1'h0;
		for (i = 0; i < 3 * B; i++) begin
			cyc(1);
			on |= led[7];
			off |= !led[7];
		end
		check({on, off, led[1:0]}, 4'hd);
		for (i = 0; i < 3; i++) begin
			hold(D + 10);
			cyc(D + 4);
			check(led[1:0], (i % 2) ? 2'h1 : 2'h2);
		end
		hold(D + L + 10);
		cyc(4);
		check({mon, blank, led[7]}, 3'h0);
		st(32'h0000_0002);
		rchk(`VMSC_OFS_IRQ_STAT, 32'h0000_0003, 32'h0000_0003);
		done("setting");
		// Monitoring off: fail LED and LED zero flash, then run
		boot(1'h0);
		cyc(T + 6);
		st(32'h0000_0001);
		acc = 8'h00;
		for (i = 0; i < 2 * B; i++) begin
			cyc(1);
			acc |= led;
		end
		check(acc, 8'ha2);
		cyc(N);
		st(32'h0000_0002);
		check(led, 8'h20);
		done("nomon");
		// Power loss in setting mode drops the change
		hold(D + L + 10);
		cyc(D + 4);
		hold(D + 10);
		cyc(D + 4);
		check(led[1:0], 2'h1);
		boot(1'h0);
		check(mon, 1'h0);
		cyc(T + N + 10);
		st(32'h0000_0002);
		done("discard");
		cyc(W);
		hold(D + L + 10);
		cyc(4);
		st(32'h0000_0002);
		done("window");
		// Press during power-up locks into the running light
		boot(1'h1);
		cyc(T);
		press <= 1'h0;
		st(32'h0000_0004);
		acc = 8'h00;
		for (i = 0; i < 7 * B; i++) begin
			cyc(1);
			acc |= led;
		end
		check(acc, 8'hfc);
		xfer(1'h1, `VMSC_OFS_IRQ_MASK, 32'h0000_0004);
		hold(D + L + 10);
		cyc(D + 4);
		st(32'h0000_0004);
		check({run, irq}, 2'h1);
		done("locked");
		end_of_test();
	end
endmodule // voltage_monitor_setting_ctrl_tb
`default_nettype wire
